// ---- hdl/wwd_map.svh ----
// Offsets, field positions, reset values and divider constants of the watchdog
`ifndef WWD_MAP_SVH
`define WWD_MAP_SVH

// Register byte offsets
`define WWD_RSTCTL_ADDR 8'h00
`define WWD_STAT_ADDR 8'h04

// Reset control register fields
`define WWD_RSTCTL_SWEN 5
`define WWD_RSTCTL_TOF 4
`define WWD_RSTCTL_SLEEP 3
`define WWD_RSTCTL_IDLE 2
`define WWD_RSTCTL_RESET 32'h0000_0000

// Status register fields
`define WWD_STAT_ON 24
`define WWD_STAT_WINOPEN 25
`define WWD_STAT_SAVE 26

// Configuration word fields
`define WWD_CFG_EN 7
`define WWD_CFG_WINOFF 6
`define WWD_CFG_PRE 4
`define WWD_CFG_POST_HI 3
`define WWD_CFG_POST_LO 0

// Prescaler terminal counts and their powers of two
`define WWD_PRE_SHORT 7'h1f
`define WWD_PRE_LONG 7'h7f
`define WWD_PRE_SHIFT_SHORT 5'h05
`define WWD_PRE_SHIFT_LONG 5'h07

// Closed part of the period, in eighths, per window size code
`define WWD_WIN_CLOSED_25 4'h6
`define WWD_WIN_CLOSED_375 4'h5
`define WWD_WIN_CLOSED_50 4'h4
`define WWD_WIN_CLOSED_75 4'h2

// Nominal source rate in hertz
`define WWD_OSC_HZ 32000

`endif

// ---- hdl/wwd_pkg.sv ----
// Types shared by the watchdog modules
package wwd_pkg;

    typedef enum logic [1:0] {
        WWD_RUN = 2'b01,
        WWD_SAVE = 2'b10
    } wwd_mode_t;

    typedef logic [21:0] wwd_pos_t;

    typedef logic [22:0] wwd_span_t;

endpackage : wwd_pkg

// ---- hdl/wwd_sync.sv ----
// Three-stage synchroniser with agreement filter and rising edge pulse
`timescale 1ns/100ps
module wwd_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic level,
    output logic rise
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic filt_q;
    logic prev_q;

    // Stage chain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Change accepted once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            filt_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            if (s2_q == s3_q) begin
                filt_q <= s3_q;
            end
            prev_q <= filt_q;
        end
    end

    assign level = filt_q;
    assign rise = filt_q & ~prev_q;

endmodule : wwd_sync

// ---- hdl/wwd_divider.sv ----
// Clearable counter stage with terminal count output
`timescale 1ns/100ps
module wwd_divider #(
    parameter int WIDTH = 15
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic step,
    input wire logic [WIDTH-1:0] limit,
    output logic [WIDTH-1:0] count,
    output logic tc
);
    logic [WIDTH-1:0] cnt_q;

    // Count steps, wrap at limit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (clear) begin
            cnt_q <= '0;
        end else if (step) begin
            if (cnt_q == limit) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    assign count = cnt_q;
    assign tc = step & (cnt_q == limit);

endmodule : wwd_divider

// ---- hdl/wwd_top.sv ----
// Windowed watchdog timer with AHB-Lite register slave
//
// Notes on behaviour
// - Counts on low-power RC ticks; enabling the watchdog enables that oscillator.
// - Prescaler divides source by 32 or by 128.
// - Postscaler divides further, 16 ratios from 1:1 to 1:32768.
// - Nominal 32 kHz source gives periods from about 1 ms to 131 s.
// - Any device reset zeroes counter, prescaler and postscaler.
// - Completed clock switch clears all counts.
// - Power-save instruction entering sleep or idle clears all counts.
// - Leaving sleep or idle clears all counts again.
// - Clear instruction in normal running clears all counts.
// - Keeps counting in sleep and idle; time-out wakes the device.
// - Configuration enable set keeps watchdog running; software cannot stop it.
// - Configuration enable clear: runs only while software enable bit set.
// - Every device reset clears the software enable bit.
// - Time-out sets a sticky flag; software clears it.
// - Window mode when window disable bit is 0; clears belong in the window.
// - Window size code gives open window of 25, 37.5, 50 or 75 percent.
// - Prescale select 1 divides by 128, 0 divides by 32.
// - Clear while disabled in hardware and software never resets the device.
//
// Register access over AHB-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "wwd_map.svh"
module wwd_top
    import wwd_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic low_power_rc_osc,
    output logic low_power_rc_osc_enable,
    input wire logic [7:0] watchdog_config_word,
    input wire logic [1:0] window_size_select,
    input wire logic watchdog_clear_instr,
    input wire logic power_save_instr,
    input wire logic power_save_idle,
    input wire logic power_save_exit,
    input wire logic clock_switch_done,
    output logic watchdog_reset_req,
    output logic watchdog_wake_req
);
    // Register state
    logic sw_en_q;
    logic tof_q;
    logic sleep_q;
    logic idle_q;
    wwd_mode_t mode_q;
    logic osc_en_q;
    logic rst_issue_q;
    logic wake_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic hresp_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;

    // Combinational nets
    logic cfg_en;
    logic win_mode;
    logic pre_long;
    logic [3:0] post_sel;
    logic wdt_on;
    logic osc_tick;
    logic pre_step;
    logic [6:0] pre_limit;
    logic [6:0] pre_cnt;
    logic pre_tc;
    logic [14:0] post_limit;
    logic [14:0] post_cnt;
    logic post_tc;
    logic timeout;
    wwd_pos_t pos;
    wwd_span_t closed_span;
    logic win_open;
    logic clr_run;
    logic clr_early;
    logic clr_good;
    logic ps_enter;
    logic ps_leave;
    logic cnt_clear;
    logic addr_phase;
    logic ctl_wr;

    // Position of the count within the time-out period
    function automatic wwd_pos_t position(input logic [14:0] post, input logic [6:0] pre,
                                          input logic lng);
        wwd_pos_t p;
        p = '0;
        if (lng) begin
            p = wwd_pos_t'({post, pre});
        end else begin
            p = wwd_pos_t'({post, pre[4:0]});
        end
        return p;
    endfunction : position

    // Closed part of the period ahead of the open window
    function automatic wwd_span_t closed_part(input logic [1:0] win, input logic [3:0] post,
                                              input logic lng);
        logic [3:0] eighths;
        logic [4:0] shift;
        wwd_span_t span;
        eighths = `WWD_WIN_CLOSED_75;
        shift = lng ? `WWD_PRE_SHIFT_LONG : `WWD_PRE_SHIFT_SHORT;
        span = '0;
        unique case (win)
            2'b11: eighths = `WWD_WIN_CLOSED_25;
            2'b10: eighths = `WWD_WIN_CLOSED_375;
            2'b01: eighths = `WWD_WIN_CLOSED_50;
            2'b00: eighths = `WWD_WIN_CLOSED_75;
        endcase
        span = wwd_span_t'(eighths) << (shift + 5'(post) - 5'h03);
        return span;
    endfunction : closed_part

    // Register read decode
    function automatic logic [31:0] read_word(input logic [7:0] addr);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (addr == `WWD_RSTCTL_ADDR) begin
            w[`WWD_RSTCTL_SWEN] = sw_en_q;
            w[`WWD_RSTCTL_TOF] = tof_q;
            w[`WWD_RSTCTL_SLEEP] = sleep_q;
            w[`WWD_RSTCTL_IDLE] = idle_q;
        end else if (addr == `WWD_STAT_ADDR) begin
            w[21:0] = pos;
            w[`WWD_STAT_ON] = wdt_on;
            w[`WWD_STAT_WINOPEN] = win_open;
            w[`WWD_STAT_SAVE] = (mode_q == WWD_SAVE);
        end
        return w;
    endfunction : read_word

    // Configuration fields
    assign cfg_en = watchdog_config_word[`WWD_CFG_EN];
    assign win_mode = ~watchdog_config_word[`WWD_CFG_WINOFF];
    assign pre_long = watchdog_config_word[`WWD_CFG_PRE];
    assign post_sel = watchdog_config_word[`WWD_CFG_POST_HI:`WWD_CFG_POST_LO];

    assign wdt_on = cfg_en | sw_en_q;

    // Oscillator enable follows the watchdog enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_en_q <= 1'b0;
        end else begin
            osc_en_q <= wdt_on;
        end
    end

    // Source clock arrives from outside this domain
    wwd_sync u_osc_sync (
        .clk(hclk),
        .rst_n(hresetn),
        .async_in(low_power_rc_osc),
        .level(),
        .rise(osc_tick)
    );

    // Count only on source ticks while enabled
    assign pre_step = osc_tick & wdt_on;

    // Prescale select picks 128 or 32
    assign pre_limit = pre_long ? `WWD_PRE_LONG : `WWD_PRE_SHORT;

    // Postscale ratio is two to the power n
    assign post_limit = 15'((16'h0001 << post_sel) - 16'h0001);

    wwd_divider #(
        .WIDTH(7)
    ) u_prescale (
        .clk(hclk),
        .rst_n(hresetn),
        .clear(cnt_clear),
        .step(pre_step),
        .limit(pre_limit),
        .count(pre_cnt),
        .tc(pre_tc)
    );

    // Postscaler stepped by prescaler terminal count
    wwd_divider #(
        .WIDTH(15)
    ) u_postscale (
        .clk(hclk),
        .rst_n(hresetn),
        .clear(cnt_clear),
        .step(pre_tc),
        .limit(post_limit),
        .count(post_cnt),
        .tc(post_tc)
    );

    // Period is prescale times postscale source ticks
    assign timeout = post_tc;

    // Window position
    assign pos = position(post_cnt, pre_cnt, pre_long);
    assign closed_span = closed_part(window_size_select, post_sel, pre_long);
    assign win_open = ~win_mode | (wwd_span_t'(pos) >= closed_span);

    // Clear before the window opens is early
    // Disabled watchdog ignores the clear entirely
    assign clr_run = watchdog_clear_instr & (mode_q == WWD_RUN);
    assign clr_early = clr_run & wdt_on & ~win_open;
    assign clr_good = clr_run & ~clr_early;

    // Power-save entry and exit events
    assign ps_enter = power_save_instr & (mode_q == WWD_RUN);
    assign ps_leave = (mode_q == WWD_SAVE) & (power_save_exit | timeout);

    // Device reset from this block clears counts
    assign cnt_clear = rst_issue_q | clock_switch_done | ps_enter | ps_leave | clr_good
        | ~wdt_on;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q <= WWD_RUN;
        end else begin
            unique case (mode_q)
                WWD_RUN: begin
                    if (ps_enter && !rst_issue_q) begin
                        mode_q <= WWD_SAVE;
                    end
                end
                WWD_SAVE: begin
                    if (ps_leave || rst_issue_q) begin
                        mode_q <= WWD_RUN;
                    end
                end
                default: begin
                    mode_q <= WWD_RUN;
                end
            endcase
        end
    end

    // Device reset on normal time-out or early clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_issue_q <= 1'b0;
        end else begin
            rst_issue_q <= ((mode_q == WWD_RUN) & timeout) | clr_early;
        end
    end

    // Time-out in power save wakes the device
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= (mode_q == WWD_SAVE) & timeout;
        end
    end

    // Bus address phase capture
    assign addr_phase = hsel & htrans[1] & hready;
    assign ctl_wr = wr_pend_q & (wr_addr_q == `WWD_RSTCTL_ADDR);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else if (hready) begin
            wr_pend_q <= addr_phase & hwrite;
            wr_addr_q <= {haddr[7:2], 2'b00};
        end
    end

    // Read data prepared at address phase, held in data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            hrdata_q <= read_word({haddr[7:2], 2'b00});
        end
    end

    // Zero wait state, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end else begin
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end
    end

    // Software enable cleared by any device reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_en_q <= 1'b0;
        end else if (rst_issue_q) begin
            sw_en_q <= 1'b0;
        end else if (ctl_wr) begin
            sw_en_q <= hwdata[`WWD_RSTCTL_SWEN];
        end
    end

    // Sticky time-out flag, set wins over clear
    // Flag set with the issued reset or wake request
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tof_q <= 1'b0;
        end else if (timeout || clr_early) begin
            tof_q <= 1'b1;
        end else if (ctl_wr && !hwdata[`WWD_RSTCTL_TOF]) begin
            tof_q <= 1'b0;
        end
    end

    // Sleep and idle status, cleared by software
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sleep_q <= 1'b0;
            idle_q <= 1'b0;
        end else begin
            if (ps_enter && !power_save_idle) begin
                sleep_q <= 1'b1;
            end else if (ctl_wr && !hwdata[`WWD_RSTCTL_SLEEP]) begin
                sleep_q <= 1'b0;
            end
            if (ps_enter && power_save_idle) begin
                idle_q <= 1'b1;
            end else if (ctl_wr && !hwdata[`WWD_RSTCTL_IDLE]) begin
                idle_q <= 1'b0;
            end
        end
    end

    // Outputs
    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign low_power_rc_osc_enable = osc_en_q;
    assign watchdog_reset_req = rst_issue_q;
    assign watchdog_wake_req = wake_q;

endmodule : wwd_top

// ---- dv/wwd_top_properties.sv ----
// Port timing checker for the windowed watchdog
`timescale 1ns/100ps
module wwd_top_properties (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic low_power_rc_osc,
    input wire logic low_power_rc_osc_enable,
    input wire logic [7:0] watchdog_config_word,
    input wire logic watchdog_clear_instr,
    input wire logic power_save_instr,
    input wire logic power_save_exit,
    input wire logic watchdog_reset_req,
    input wire logic watchdog_wake_req
);
    logic [1:0] up_q;
    logic [3:0] osc_age_q;
    logic [1:0] clr_age_q;
    logic save_q;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Age of last tick edge and clear, power save state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            up_q <= 2'h0;
            osc_age_q <= 4'hf;
            clr_age_q <= 2'h3;
            save_q <= 1'b0;
        end else begin
            up_q <= (up_q == 2'h3) ? up_q : up_q + 2'h1;
            osc_age_q <= $rose(low_power_rc_osc) ? 4'h0 :
                ((osc_age_q == 4'hf) ? osc_age_q : osc_age_q + 4'h1);
            clr_age_q <= watchdog_clear_instr ? 2'h0 :
                ((clr_age_q == 2'h3) ? clr_age_q : clr_age_q + 2'h1);
            if (power_save_instr) begin
                save_q <= 1'b1;
            end else if (power_save_exit || watchdog_wake_req) begin
                save_q <= 1'b0;
            end
        end
    end
    a_reset_one_cycle: assert property (watchdog_reset_req |=> !watchdog_reset_req)
        else $error("reset request longer than one cycle");
    a_wake_one_cycle: assert property (watchdog_wake_req |=> !watchdog_wake_req)
        else $error("wake request longer than one cycle");
    a_req_exclusive: assert property (!(watchdog_reset_req && watchdog_wake_req))
        else $error("reset and wake together");
    a_hw_enable_osc: assert property ((up_q == 2'h3) && $past(watchdog_config_word[7])
        |-> low_power_rc_osc_enable) else $error("oscillator off while enabled");
    a_clear_disabled: assert property (watchdog_clear_instr && !low_power_rc_osc_enable
        ##1 !low_power_rc_osc_enable |-> !watchdog_reset_req)
        else $error("disabled clear reset the device");
    a_reset_has_cause: assert property (watchdog_reset_req
        |-> (osc_age_q < 4'hc) || (clr_age_q < 2'h2)) else $error("reset without cause");
    a_wake_in_save: assert property (watchdog_wake_req |-> save_q)
        else $error("wake outside power save");
    a_no_reset_saving: assert property (watchdog_reset_req |-> !save_q)
        else $error("reset during power save");
endmodule : wwd_top_properties

bind wwd_top wwd_top_properties i_props (.hclk(hclk), .hresetn(hresetn),
    .low_power_rc_osc(low_power_rc_osc), .low_power_rc_osc_enable(low_power_rc_osc_enable),
    .watchdog_config_word(watchdog_config_word), .watchdog_clear_instr(watchdog_clear_instr),
    .power_save_instr(power_save_instr), .power_save_exit(power_save_exit),
    .watchdog_reset_req(watchdog_reset_req), .watchdog_wake_req(watchdog_wake_req));

// ---- dv/tb_wwd_top.sv ----
// Self-checking bench for the windowed watchdog
`timescale 1ns/100ps
module tb_wwd_top;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, osc, osc_en, idle, rst_q, wake;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, win;
    logic [2:0] hsize;
    logic [7:0] cfg;
    logic [3:0] ev;
    int mismatches, comparisons, nrst, nwake;

    wwd_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .low_power_rc_osc(osc), .low_power_rc_osc_enable(osc_en),
        .watchdog_config_word(cfg), .window_size_select(win),
        .watchdog_clear_instr(ev[0]), .power_save_instr(ev[1]), .power_save_idle(idle),
        .power_save_exit(ev[2]), .clock_switch_done(ev[3]),
        .watchdog_reset_req(rst_q), .watchdog_wake_req(wake));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        if (rst_q === 1'b1) nrst++;
        if (wake === 1'b1) nwake++;
    end

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                mismatches++;
                summarize();
            end
            @(posedge hclk);
        end
    endtask : wait_rdy

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : bus

    task automatic tick(input int n);
        repeat (n) begin
            osc <= 1'b1;
            repeat (8) @(posedge hclk);
            osc <= 1'b0;
            repeat (8) @(posedge hclk);
        end
        repeat (8) @(posedge hclk);
    endtask : tick

    task automatic pulse(input int k);
        ev <= 4'h1 << k;
        @(posedge hclk);
        ev <= 4'h0;
        repeat (3) @(posedge hclk);
    endtask : pulse

    task automatic s_reset;
        hresetn <= 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, 8'h00, 32'h0);
        chk("reset ctl", rd, 32'h0);
        bus(1'b0, 8'h04, 32'h0);
        chk("position", {10'h0, rd[21:0]}, 32'h0);
        bus(1'b0, 8'h08, 32'h0);
        chk("unmapped", rd, 32'h0);
        chk("osc enable", {31'h0, osc_en}, 32'h0);
    endtask : s_reset

    task automatic s_enable;
        bus(1'b1, 8'h00, 32'h20);
        bus(1'b0, 8'h00, 32'h0);
        chk("sw enable", rd, 32'h20);
        bus(1'b0, 8'h04, 32'h0);
        chk("on", {31'h0, rd[24]}, 32'h1);
        chk("osc on", {31'h0, osc_en}, 32'h1);
        bus(1'b1, 8'h00, 32'h0);
        repeat (2) @(posedge hclk);
        chk("osc off", {31'h0, osc_en}, 32'h0);
    endtask : s_enable

    task automatic s_events;
        bus(1'b1, 8'h00, 32'h20);
        for (int k = 0; k < 4; k++) begin
            tick(3);
            bus(1'b0, 8'h04, 32'h0);
            chk("count", {10'h0, rd[21:0]}, 32'h3);
            pulse(k);
            bus(1'b0, 8'h04, 32'h0);
            chk("cleared", {10'h0, rd[21:0]}, 32'h0);
            chk("saving", {31'h0, rd[26]}, {31'h0, k == 1});
        end
        bus(1'b0, 8'h00, 32'h0);
        chk("sleep bit", rd, 32'h28);
        bus(1'b1, 8'h00, 32'h0);
    endtask : s_events

    task automatic s_timeout(input logic [7:0] c, input int n);
        cfg <= c;
        bus(1'b1, 8'h00, 32'h20);
        nrst = 0;
        tick(n - 1);
        chk("early timeout", nrst, 0);
        tick(1);
        chk("timeout", nrst, 1);
        bus(1'b0, 8'h00, 32'h0);
        chk("flag", rd, 32'h10);
        bus(1'b1, 8'h00, 32'h0);
        bus(1'b0, 8'h00, 32'h0);
        chk("flag clear", rd, 32'h0);
    endtask : s_timeout

    task automatic s_sleep;
        cfg <= 8'h40;
        for (int i = 0; i < 2; i++) begin
            idle <= i[0];
            bus(1'b1, 8'h00, 32'h20);
            pulse(1);
            nrst = 0;
            nwake = 0;
            tick(32);
            chk("wake", nwake, 1);
            chk("no reset", nrst, 0);
            bus(1'b0, 8'h00, 32'h0);
            chk("save status", rd, (i == 1) ? 32'h34 : 32'h38);
            bus(1'b1, 8'h00, 32'h0);
            bus(1'b0, 8'h00, 32'h0);
            chk("status cleared", rd, 32'h0);
        end
    endtask : s_sleep

    task automatic s_window;
        int closed [4] = '{8, 16, 20, 24};
        cfg <= 8'h00;
        for (int w = 0; w < 4; w++) begin
            win <= w[1:0];
            bus(1'b1, 8'h00, 32'h20);
            tick(closed[w] - 1);
            bus(1'b0, 8'h04, 32'h0);
            chk("window shut", {31'h0, rd[25]}, 32'h0);
            nrst = 0;
            pulse(0);
            chk("early clear", nrst, 1);
            bus(1'b1, 8'h00, 32'h20);
            tick(closed[w]);
            bus(1'b0, 8'h04, 32'h0);
            chk("window open", {31'h0, rd[25]}, 32'h1);
            pulse(0);
            chk("open clear", nrst, 1);
            bus(1'b1, 8'h00, 32'h0);
        end
        nrst = 0;
        pulse(0);
        chk("disabled clear", nrst, 0);
    endtask : s_window

    task automatic s_hw;
        cfg <= 8'hc0;
        bus(1'b1, 8'h00, 32'h0);
        repeat (2) @(posedge hclk);
        chk("hw osc", {31'h0, osc_en}, 32'h1);
        nrst = 0;
        tick(32);
        chk("hw timeout", nrst, 1);
        cfg <= 8'h40;
    endtask : s_hw

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        osc = 1'b0;
        idle = 1'b0;
        cfg = 8'h40;
        win = 2'h0;
        ev = 4'h0;
        s_reset();
        s_enable();
        s_events();
        s_timeout(8'h40, 32);
        s_timeout(8'h50, 128);
        s_timeout(8'h42, 128);
        s_sleep();
        s_window();
        s_hw();
        bus(1'b1, 8'h00, 32'h20);
        tick(5);
        s_reset();
        summarize();
    end

    initial begin
        repeat (100000) @(posedge hclk);
        mismatches++;
        summarize();
    end
endmodule : tb_wwd_top
